// ### rtl/pcnt_defines.vh
`ifndef PCNT_DEFINES_VH
`define PCNT_DEFINES_VH
`define PCNT_CNT_MAX 32'h7FFF_FFFF
`define PCNT_CNT_MIN 32'h8000_0000
`define PCNT_ZERO 32'h0000_0000
`define PCNT_MODE_CONT 2'h0
`define PCNT_MODE_ONCE 2'h1
`define PCNT_MODE_PERIOD 2'h2
`define PCNT_DIR_NONE 2'h0
`define PCNT_DIR_UP 2'h1
`define PCNT_DIR_DOWN 2'h2
`define PCNT_AUX_INPUT 2'h0
`define PCNT_AUX_GATE 2'h1
`define PCNT_AUX_LATCH 2'h2
`define PCNT_AUX_SYNC 2'h3
`define PCNT_OUT_PLAIN 3'h0
`define PCNT_OUT_GE 3'h1
`define PCNT_OUT_LE 3'h2
`define PCNT_OUT_PULSE 3'h3
`define PCNT_OUT_SWITCH 3'h4
`define PCNT_STEP 32'h0000_0001
`endif

// ### rtl/pcnt_sync.v
`timescale 1ns/1ps
// three-stage synchroniser; a change is accepted once stages two and three agree
module pcnt_sync (
  input wire sys_clk,
  input wire rst,
  input wire din,
  output reg dout
);
  reg s1_reg;
  reg s2_reg;
  reg s3_reg;
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        dout <= s3_reg;
      end
    end
  end
endmodule // pcnt_sync

// ### rtl/pcnt_top.v
// Behaviour
// RQ1 - count is a signed 32-bit value, lowest value -2147483648
// RQ2 - continuous mode upper limit is +2147483647
// RQ3 - continuous: up pulse at upper limit wraps to lower limit
// RQ4 - continuous: down pulse at lower limit wraps to upper limit
// RQ5 - load value applied directly or staged until a qualifying event
// RQ6 - once/periodic: staged value loaded at upper limit (up) or zero (down)
// RQ7 - staged value loaded on gate start, sync, latch-retrigger; not on resume
// RQ8 - step direction comes from encoder signals only
// RQ9 - after configuration values reset to 0, or upper limit when direction down
// RQ10 - control words taken every cycle, answer returned same cycle
// RQ11 - feedback holds value and status as at the capture moment
// RQ12 - events after the capture moment appear in the next cycle
// RQ13 - once, no direction: passing a limit clamps and closes gate
// RQ14 - once, up: reaching upper limit reloads and closes gate
// RQ15 - direction up: configurable upper limit, load value starts at zero
// RQ16 - once, down: reaching lower limit reloads and closes gate
// RQ17 - direction down: lower limit is zero, upper-limit setting is load value
// RQ18 - after auto closure only controller reopening restarts counting
// RQ19 - once, interrupting gate: reopening after underflow keeps the value
// RQ20 - aux input role: plain input, pin gate, latch or sync
// RQ21 - outputs plain, >=, <=, or pulse; only output one switches two values
// RQ22 - staged value, count, compares and output setting changeable at run time
// RQ23 - count only while program gate and pin gate are open
// RQ24 - program gate opens on rising edge of its bit, closes when cleared
// RQ25 - open gate: one step per decoded pulse in encoder direction
`timescale 1ns/1ps
`include "pcnt_defines.vh"
module pcnt_top (
  input wire sys_clk,
  input wire rst,
  input wire enc_a_pin,
  input wire enc_b_pin,
  input wire aux_input_pin,
  input wire config_load,
  input wire [1:0] count_mode,
  input wire [1:0] main_direction,
  input wire [31:0] upper_limit_setting,
  input wire [1:0] aux_role,
  input wire gate_interrupting,
  input wire [2:0] output_one_mode,
  input wire [2:0] output_two_mode,
  input wire output_behaviour_setting,
  input wire program_gate_bit,
  input wire output_one_ctrl,
  input wire output_two_ctrl,
  input wire direct_count_strobe,
  input wire [31:0] direct_count_write,
  input wire staged_strobe,
  input wire [31:0] staged_reload_value,
  input wire compare_strobe,
  input wire [31:0] compare_value_one,
  input wire [31:0] compare_value_two,
  input wire feedback_capture_moment,
  output reg [31:0] feedback_value,
  output reg feedback_gate,
  output reg feedback_aux,
  output reg feedback_out_one,
  output reg feedback_out_two,
  output reg output_pin_one,
  output reg output_pin_two,
  output wire gate_open
);
  wire a_s;
  wire b_s;
  wire aux_s;
  pcnt_sync u_sync_a (.sys_clk(sys_clk), .rst(rst), .din(enc_a_pin), .dout(a_s));
  pcnt_sync u_sync_b (.sys_clk(sys_clk), .rst(rst), .din(enc_b_pin), .dout(b_s));
  pcnt_sync u_sync_aux (.sys_clk(sys_clk), .rst(rst), .din(aux_input_pin), .dout(aux_s));

  reg [31:0] count_reg;
  reg [31:0] count_next;
  reg [31:0] staged_reg;
  reg [31:0] cmp1_reg;
  reg [31:0] cmp2_reg;
  reg [31:0] latch_reg;
  reg [31:0] latch_next;
  reg [1:0] mode_reg;
  reg [1:0] dir_reg;
  reg [31:0] ulim_reg;
  reg a_d_reg;
  reg aux_d_reg;
  reg pgm_d_reg;
  reg program_gate_bit_reg;
  reg program_gate_bit_next;
  reg pin_gate_reg;
  reg latched_reg;
  reg latched_next;
  reg out_sel_reg;
  reg o1_next;
  reg o2_next;
  reg was_open_reg;
  reg auto_closed;

  // quadrature x1: step on a rising edge of A, B low = up
  wire step;
  wire step_up;
  wire aux_rise;
  wire aux_fall;
  wire pin_gate_used;
  wire gate_start;
  wire [31:0] hi_lim;
  wire [31:0] lo_lim;
  wire [31:0] cnt_inc;
  wire [31:0] cnt_dec;
  wire at_hi;
  wire at_lo;
  wire signed [31:0] cnt_sg;
  wire signed [31:0] c1_sg;
  wire signed [31:0] c2_sg;
  wire signed [31:0] cmp_one_sg;
  wire ge_one;
  wire le_one;
  wire ge_two;
  wire le_two;
  wire in_window;
  wire count_moves;
  wire reach_one;
  wire reach_two;
  assign step = a_s & ~a_d_reg; // [RQ8] [RQ25]
  assign step_up = ~b_s; // [RQ8]
  assign aux_rise = aux_s & ~aux_d_reg;
  assign aux_fall = ~aux_s & aux_d_reg;
  assign pin_gate_used = (aux_role == `PCNT_AUX_GATE);
  // [RQ23]
  assign gate_open = program_gate_bit_reg & (pin_gate_used ? pin_gate_reg : 1'b1);
  assign gate_start = gate_open & ~was_open_reg;
  assign hi_lim = (dir_reg == `PCNT_DIR_UP) ? ulim_reg : `PCNT_CNT_MAX; // [RQ2] [RQ15]
  assign lo_lim = (dir_reg == `PCNT_DIR_DOWN) ? `PCNT_ZERO : `PCNT_CNT_MIN; // [RQ1] [RQ17]
  // plain 32-bit add and subtract carry max onto min and back by themselves
  assign cnt_inc = count_reg + `PCNT_STEP;
  assign cnt_dec = count_reg - `PCNT_STEP;
  assign at_hi = (count_reg == hi_lim);
  assign at_lo = (count_reg == lo_lim);
  assign cnt_sg = count_reg;
  assign c1_sg = cmp1_reg;
  assign c2_sg = cmp2_reg;
  assign cmp_one_sg = out_sel_reg ? c2_sg : c1_sg;
  // signed compares, so a negative count sits below a positive compare value
  assign ge_one = (cnt_sg >= cmp_one_sg);
  assign le_one = (cnt_sg <= cmp_one_sg);
  assign ge_two = (cnt_sg >= c2_sg);
  assign le_two = (cnt_sg <= c2_sg);
  assign in_window = (cnt_sg >= c1_sg) & (cnt_sg <= c2_sg);
  assign count_moves = (count_next != count_reg);
  assign reach_one = (count_next == cmp1_reg) & count_moves;
  assign reach_two = (count_next == cmp2_reg) & count_moves;

  // the reset value depends on direction, so configuration reloads it
  wire [31:0] cfg_reset_val = (main_direction == `PCNT_DIR_DOWN) ?
    upper_limit_setting : `PCNT_ZERO; // [RQ9]

  always @* begin
    count_next = count_reg;
    latch_next = latch_reg;
    latched_next = latched_reg;
    auto_closed = 1'b0;
    // interrupting gate resumes from the held value, canceling one reloads [RQ19]
    if (gate_start & ~gate_interrupting) begin
      count_next = staged_reg; // [RQ7]
    end else if (gate_open & aux_rise & (aux_role == `PCNT_AUX_LATCH)) begin
      latch_next = count_reg;
      latched_next = 1'b1;
      count_next = staged_reg; // [RQ7]
    end else if (aux_rise & (aux_role == `PCNT_AUX_SYNC)) begin
      count_next = staged_reg; // [RQ7]
    end else if (direct_count_strobe) begin
      count_next = direct_count_write; // [RQ5] [RQ22]
    end else if (gate_open & step) begin
      if (mode_reg == `PCNT_MODE_CONT) begin
        if (step_up) begin
          count_next = cnt_inc; // [RQ3] max+1 wraps to min
        end else begin
          count_next = cnt_dec; // [RQ4] min-1 wraps to max
        end
      end else if (dir_reg == `PCNT_DIR_NONE) begin
        if (step_up & at_hi) begin
          count_next = (mode_reg == `PCNT_MODE_ONCE) ? hi_lim : staged_reg; // [RQ13] [RQ6]
          auto_closed = (mode_reg == `PCNT_MODE_ONCE);
        end else if (~step_up & at_lo) begin
          count_next = (mode_reg == `PCNT_MODE_ONCE) ? lo_lim : staged_reg; // [RQ13] [RQ6]
          auto_closed = (mode_reg == `PCNT_MODE_ONCE);
        end else begin
          count_next = step_up ? cnt_inc : cnt_dec; // [RQ25]
        end
      end else if (dir_reg == `PCNT_DIR_UP) begin
        count_next = step_up ? cnt_inc : cnt_dec;
        if (step_up & (cnt_inc == hi_lim)) begin
          count_next = staged_reg; // [RQ6] [RQ14]
          auto_closed = (mode_reg == `PCNT_MODE_ONCE); // [RQ14]
        end
      end else begin
        count_next = step_up ? cnt_inc : cnt_dec;
        if (~step_up & (cnt_dec == lo_lim)) begin
          count_next = staged_reg; // [RQ6] [RQ16]
          auto_closed = (mode_reg == `PCNT_MODE_ONCE); // [RQ16]
        end
      end
    end
  end

  // auto closure beats a steady high bit: only a fresh rising edge reopens
  always @* begin
    program_gate_bit_next = program_gate_bit_reg;
    // [RQ24] open only on rising edge of the bit, close when cleared
    if (~program_gate_bit) begin
      program_gate_bit_next = 1'b0;
    end else if (~pgm_d_reg) begin
      program_gate_bit_next = 1'b1; // [RQ18]
    end
    if (auto_closed) begin
      program_gate_bit_next = 1'b0; // [RQ13] [RQ18]
    end
  end

  // output one alone may switch its reference or use the window
  always @* begin
    o1_next = output_one_ctrl;
    o2_next = output_two_ctrl;
    case (output_one_mode)
      `PCNT_OUT_GE: begin
        o1_next = ge_one; // [RQ21]
      end
      `PCNT_OUT_LE: begin
        o1_next = le_one;
      end
      `PCNT_OUT_PULSE: begin
        o1_next = reach_one;
      end
      `PCNT_OUT_SWITCH: begin
        o1_next = in_window;
      end
      default: begin
        o1_next = output_one_ctrl;
      end
    endcase
    case (output_two_mode)
      `PCNT_OUT_GE: begin
        o2_next = ge_two; // [RQ21]
      end
      `PCNT_OUT_LE: begin
        o2_next = le_two;
      end
      `PCNT_OUT_PULSE: begin
        o2_next = reach_two;
      end
      default: begin
        o2_next = output_two_ctrl;
      end
    endcase
  end

  // edge detectors idle low like their pins, so no false edge follows reset
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      a_d_reg <= 1'b0;
      aux_d_reg <= 1'b0;
      pgm_d_reg <= 1'b0;
    end else begin
      a_d_reg <= a_s;
      aux_d_reg <= aux_s;
      pgm_d_reg <= program_gate_bit;
    end
  end

  // pin gate tracks the aux edges in every role, so a later role change finds it current
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin_gate_reg <= 1'b0;
    end else if (aux_rise) begin
      pin_gate_reg <= 1'b1; // [RQ20]
    end else if (aux_fall) begin
      pin_gate_reg <= 1'b0;
    end
  end

  // configuration outranks every other write [RQ9]
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      count_reg <= `PCNT_ZERO;
      staged_reg <= `PCNT_ZERO;
      cmp1_reg <= `PCNT_ZERO;
      cmp2_reg <= `PCNT_ZERO;
      latch_reg <= `PCNT_ZERO;
      mode_reg <= `PCNT_MODE_CONT;
      dir_reg <= `PCNT_DIR_NONE;
      ulim_reg <= `PCNT_CNT_MAX;
      program_gate_bit_reg <= 1'b0;
      latched_reg <= 1'b0;
      was_open_reg <= 1'b0;
    end else if (config_load) begin
      mode_reg <= count_mode;
      dir_reg <= main_direction;
      ulim_reg <= upper_limit_setting; // [RQ15]
      count_reg <= cfg_reset_val; // [RQ9]
      staged_reg <= cfg_reset_val; // [RQ9] [RQ17]
      cmp1_reg <= cfg_reset_val;
      cmp2_reg <= cfg_reset_val;
      latch_reg <= cfg_reset_val;
      latched_reg <= 1'b0;
      program_gate_bit_reg <= 1'b0;
      was_open_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      program_gate_bit_reg <= program_gate_bit_next;
      latch_reg <= latch_next;
      latched_reg <= latched_next;
      was_open_reg <= gate_open;
      if (staged_strobe) begin
        staged_reg <= staged_reload_value; // [RQ5] [RQ22]
      end
      if (compare_strobe) begin
        cmp1_reg <= compare_value_one; // [RQ22]
        cmp2_reg <= compare_value_two;
      end
    end
  end

  // compare outputs lag the count by one edge, pulse outputs rise with it; the setting may change while counting
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      out_sel_reg <= 1'b0;
      output_pin_one <= 1'b0;
      output_pin_two <= 1'b0;
    end else begin
      out_sel_reg <= output_behaviour_setting; // [RQ22]
      output_pin_one <= o1_next;
      output_pin_two <= o2_next;
    end
  end

  // feedback frozen at the capture moment; later events wait a cycle [RQ11] [RQ12]
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      feedback_value <= 32'h0000_0000;
      feedback_gate <= 1'b0;
      feedback_aux <= 1'b0;
      feedback_out_one <= 1'b0;
      feedback_out_two <= 1'b0;
    end else if (feedback_capture_moment) begin
      feedback_value <= latched_reg ? latch_reg : count_reg; // [RQ10] [RQ11]
      feedback_gate <= gate_open;
      feedback_aux <= aux_s;
      feedback_out_one <= output_pin_one;
      feedback_out_two <= output_pin_two;
    end
  end
endmodule // pcnt_top

// ### sim/pcnt_top_assertions.sv
`timescale 1ns/1ps
`include "pcnt_defines.vh"
module pcnt_top_assertions (
  input wire sys_clk,
  input wire rst,
  input wire [1:0] aux_role,
  input wire [2:0] output_one_mode,
  input wire [2:0] output_two_mode,
  input wire program_gate_bit,
  input wire output_one_ctrl,
  input wire output_two_ctrl,
  input wire config_load,
  input wire feedback_capture_moment,
  input wire [31:0] feedback_value,
  input wire feedback_gate,
  input wire feedback_out_one,
  input wire output_pin_one,
  input wire output_pin_two,
  input wire gate_open
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  a_gate_needs_bit: assert property (gate_open |-> $past(program_gate_bit))
    else $error("gate open while program gate bit low");
  // the bit was low two edges back and high on the edge before the rise
  a_gate_opens_edge: assert property ($rose(gate_open) && aux_role != `PCNT_AUX_GATE
    && $past(aux_role) != `PCNT_AUX_GATE
    |-> $past(program_gate_bit) && !$past(program_gate_bit, 2))
    else $error("gate opened without a rising program bit");
  a_config_closes: assert property (config_load |=> !gate_open)
    else $error("gate still open after configuration");
  a_fb_holds: assert property (!feedback_capture_moment |=> $stable(feedback_value))
    else $error("feedback value moved without a capture");
  a_fb_gate_state: assert property (feedback_capture_moment |=> feedback_gate == $past(gate_open))
    else $error("gate status not the one at capture");
  a_fb_out_state: assert property (feedback_capture_moment
    |=> feedback_out_one == $past(output_pin_one))
    else $error("output status not the one at capture");
  a_plain_one: assert property ($past(output_one_mode) == `PCNT_OUT_PLAIN
    && output_one_mode == `PCNT_OUT_PLAIN |-> output_pin_one == $past(output_one_ctrl))
    else $error("plain output one does not follow control");
  a_plain_two: assert property ($past(output_two_mode) == `PCNT_OUT_PLAIN
    && output_two_mode == `PCNT_OUT_PLAIN |-> output_pin_two == $past(output_two_ctrl))
    else $error("plain output two does not follow control");
  c_gate_rise: cover property ($rose(gate_open));
  c_auto_close: cover property ($fell(gate_open) && program_gate_bit);
  c_capture: cover property (feedback_capture_moment);
endmodule // pcnt_top_assertions
bind pcnt_top pcnt_top_assertions pcnt_top_assertions_inst (.sys_clk, .rst, .aux_role,
  .output_one_mode, .output_two_mode, .program_gate_bit, .output_one_ctrl, .output_two_ctrl,
  .config_load, .feedback_capture_moment, .feedback_value, .feedback_gate, .feedback_out_one,
  .output_pin_one, .output_pin_two, .gate_open);

// ### sim/pcnt_ctrl_model.sv
`timescale 1ns/1ps
module pcnt_ctrl_model (
  input wire sys_clk,
  output logic enc_a_pin,
  output logic enc_b_pin,
  output logic program_gate_bit
);
  initial begin
    enc_a_pin = 1'h0;
    enc_b_pin = 1'h0;
    program_gate_bit = 1'h0;
  end
  // b settles long before a rises so the synchronisers never see them cross
  task automatic step(input logic up);
    @(posedge sys_clk);
    enc_b_pin <= ~up;
    repeat (4) @(posedge sys_clk);
    enc_a_pin <= 1'h1;
    repeat (4) @(posedge sys_clk);
    enc_a_pin <= 1'h0;
    repeat (4) @(posedge sys_clk);
  endtask
  // bit dropped first: only a fresh rising edge reopens a closed gate
  task automatic open_gate;
    @(posedge sys_clk);
    program_gate_bit <= 1'h0;
    repeat (3) @(posedge sys_clk);
    program_gate_bit <= 1'h1;
    repeat (3) @(posedge sys_clk);
  endtask
endmodule // pcnt_ctrl_model

// ### sim/test_pcnt_top.sv
`timescale 1ns/1ps
`include "pcnt_defines.vh"
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin error_cnt++; \
  $display("unexpected %s expected %h seen %h", n, e, a); end end
module test_pcnt_top;
  logic sys_clk, rst, enc_a_pin, enc_b_pin, program_gate_bit, config_load, gate_interrupting;
  logic output_one_ctrl, direct_count_strobe, staged_strobe, compare_strobe, feedback_capture_moment;
  logic feedback_gate, output_pin_one, gate_open;
  logic aux_input_pin, output_behaviour_setting, output_two_ctrl, output_pin_two;
  logic feedback_aux, feedback_out_one, feedback_out_two;
  logic [1:0] count_mode, main_direction, aux_role;
  logic [2:0] output_one_mode, output_two_mode;
  logic [31:0] upper_limit_setting, direct_count_write, staged_reload_value, compare_value_one;
  logic [31:0] compare_value_two;
  logic [31:0] feedback_value;
  int error_cnt, checked, cycles;
  pcnt_ctrl_model pcnt_ctrl_model_inst (.sys_clk, .enc_a_pin, .enc_b_pin, .program_gate_bit);
  pcnt_top pcnt_top_inst (.sys_clk, .rst, .enc_a_pin, .enc_b_pin, .aux_input_pin,
    .config_load, .count_mode, .main_direction, .upper_limit_setting, .aux_role,
    .gate_interrupting, .output_one_mode, .output_two_mode, .output_behaviour_setting,
    .program_gate_bit, .output_one_ctrl, .output_two_ctrl, .direct_count_strobe,
    .direct_count_write, .staged_strobe, .staged_reload_value, .compare_strobe, .compare_value_one,
    .compare_value_two, .feedback_capture_moment, .feedback_value,
    .feedback_gate, .feedback_aux, .feedback_out_one, .feedback_out_two, .output_pin_one,
    .output_pin_two, .gate_open);
  initial begin
    sys_clk = 1'h0;
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // generous ceiling: the whole sequence needs a few hundred cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      $display("unexpected timeout");
      tally_and_finish();
    end
  end
  task automatic cfg(input logic [1:0] m, input logic [1:0] d, input logic [31:0] ul);
    count_mode <= m;
    main_direction <= d;
    upper_limit_setting <= ul;
    config_load <= 1'h1;
    @(posedge sys_clk);
    config_load <= 1'h0;
    @(posedge sys_clk);
  endtask
  task automatic put(input logic [31:0] v);
    direct_count_write <= v;
    direct_count_strobe <= 1'h1;
    @(posedge sys_clk);
    direct_count_strobe <= 1'h0;
    @(posedge sys_clk);
  endtask
  task automatic stage(input logic [31:0] v);
    staged_reload_value <= v;
    staged_strobe <= 1'h1;
    @(posedge sys_clk);
    staged_strobe <= 1'h0;
    @(posedge sys_clk);
  endtask
  task automatic pin_aux(input logic v);
    aux_input_pin <= v;
    repeat (6) @(posedge sys_clk);
  endtask
  task automatic fb(input logic [31:0] e, input logic g);
    feedback_capture_moment <= 1'h1;
    @(posedge sys_clk);
    feedback_capture_moment <= 1'h0;
    @(posedge sys_clk);
    @(negedge sys_clk);
    `CHK("feedback value", e, feedback_value)
    `CHK("gate status", g, feedback_gate)
    @(posedge sys_clk);
  endtask
  initial begin
    {rst, config_load, gate_interrupting, output_one_ctrl, direct_count_strobe} = 5'h10;
    {aux_input_pin, aux_role, output_two_mode, output_behaviour_setting, output_two_ctrl} = 8'h00;
    compare_value_two = 32'h0000_0000;
    {staged_strobe, compare_strobe, feedback_capture_moment, count_mode, main_direction} = 7'h00;
    {output_one_mode, upper_limit_setting, direct_count_write} = 67'h0;
    {staged_reload_value, compare_value_one} = 64'h0;
    repeat (5) @(posedge sys_clk);
    rst <= 1'h0;
    output_one_ctrl <= 1'h1;
    output_two_ctrl <= 1'h1;
    cfg(`PCNT_MODE_CONT, `PCNT_DIR_DOWN, 32'h0000_0064);
    fb(32'h0000_0064, 1'h0);
    cfg(`PCNT_MODE_CONT, `PCNT_DIR_UP, 32'h0000_0064);
    fb(`PCNT_ZERO, 1'h0);
    @(negedge sys_clk);
    `CHK("output two", 1'h1, output_pin_two)
    @(posedge sys_clk);
    $display("test reset_values done");
    cfg(`PCNT_MODE_CONT, `PCNT_DIR_NONE, `PCNT_CNT_MAX);
    pcnt_ctrl_model_inst.open_gate();
    put(`PCNT_CNT_MAX);
    pcnt_ctrl_model_inst.step(1'h1);
    fb(`PCNT_CNT_MIN, 1'h1);
    pcnt_ctrl_model_inst.step(1'h0);
    fb(`PCNT_CNT_MAX, 1'h1);
    pcnt_ctrl_model_inst.step(1'h0);
    fb(32'h7FFF_FFFE, 1'h1);
    $display("test wrap done");
    cfg(`PCNT_MODE_ONCE, `PCNT_DIR_UP, 32'h0000_000A);
    stage(32'h0000_0003);
    pcnt_ctrl_model_inst.open_gate();
    fb(32'h0000_0003, 1'h1);
    put(32'h0000_0009);
    pcnt_ctrl_model_inst.step(1'h1);
    fb(32'h0000_0003, 1'h0);
    pcnt_ctrl_model_inst.step(1'h1);
    fb(32'h0000_0003, 1'h0);
    cfg(`PCNT_MODE_ONCE, `PCNT_DIR_DOWN, 32'h0000_000A);
    pcnt_ctrl_model_inst.open_gate();
    put(32'h0000_0001);
    pcnt_ctrl_model_inst.step(1'h0);
    fb(32'h0000_000A, 1'h0);
    cfg(`PCNT_MODE_ONCE, `PCNT_DIR_NONE, `PCNT_CNT_MAX);
    pcnt_ctrl_model_inst.open_gate();
    put(`PCNT_CNT_MIN);
    pcnt_ctrl_model_inst.step(1'h0);
    fb(`PCNT_CNT_MIN, 1'h0);
    gate_interrupting <= 1'h1;
    pcnt_ctrl_model_inst.open_gate();
    fb(`PCNT_CNT_MIN, 1'h1);
    $display("test once_only done");
    output_one_mode <= `PCNT_OUT_GE;
    compare_value_one <= 32'h0000_0005;
    output_two_mode <= `PCNT_OUT_LE;
    compare_value_two <= 32'h0000_0004;
    compare_strobe <= 1'h1;
    @(posedge sys_clk);
    compare_strobe <= 1'h0;
    put(32'h0000_0005);
    @(negedge sys_clk);
    `CHK("output one", 1'h1, output_pin_one)
    `CHK("output two", 1'h0, output_pin_two)
    @(posedge sys_clk);
    put(32'h0000_0004);
    @(negedge sys_clk);
    `CHK("output one", 1'h0, output_pin_one)
    `CHK("output two", 1'h1, output_pin_two)
    @(posedge sys_clk);
    output_behaviour_setting <= 1'h1;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    `CHK("output one", 1'h1, output_pin_one)
    @(posedge sys_clk);
    fb(32'h0000_0004, 1'h1);
    `CHK("output status", 1'h1, feedback_out_one)
    `CHK("output status", 1'h1, feedback_out_two)
    $display("test outputs done");
    cfg(`PCNT_MODE_PERIOD, `PCNT_DIR_NONE, `PCNT_CNT_MAX);
    stage(32'h0000_0007);
    aux_role <= `PCNT_AUX_SYNC;
    pin_aux(1'h1);
    fb(32'h0000_0007, 1'h0);
    pin_aux(1'h0);
    pcnt_ctrl_model_inst.open_gate();
    put(`PCNT_CNT_MAX);
    pcnt_ctrl_model_inst.step(1'h1);
    fb(32'h0000_0007, 1'h1);
    aux_role <= `PCNT_AUX_GATE;
    pcnt_ctrl_model_inst.step(1'h1);
    fb(32'h0000_0007, 1'h0);
    pin_aux(1'h1);
    pcnt_ctrl_model_inst.step(1'h1);
    fb(32'h0000_0008, 1'h1);
    aux_role <= `PCNT_AUX_LATCH;
    pin_aux(1'h0);
    pin_aux(1'h1);
    fb(32'h0000_0008, 1'h1);
    `CHK("aux status", 1'h1, feedback_aux)
    $display("test aux_roles done");
    tally_and_finish();
  end
endmodule // test_pcnt_top
